// >>> soc_params.svh
/*
  Constants of the switch output command handler: register offsets, field
  positions, reset values, ASCII codes and reply lengths.
  Assumes inclusion by bare name from every file that needs a figure.
*/
// Function
// - The gate-activate character opens the reading gate, which stays open until a close source ends it.
// - The gate-deactivate character closes the gate at once and gets no reply.
// - A gate closed by command emits its read result at once without waiting for a trigger.
// - A gate closed by command reports a failed read, as no success criterion was met.
// - The single-port activate form names port 1 or 2, drives it active and gets no reply.
// - Port states are logical levels passed through each port's inversion, so inverted high gives 0 V.
// - The query reports both ports, showing output ports at the state set by command.
// - The query shows low as 0, high as 1, and an input or passive port by its role letter.
// - The set form takes optional per-port fields of 0 or 1 and applies each as that port's logical state.
// - The set form silently ignores values for ports not set up as switching output.
// - The set form is answered with a two-digit code: 00 ok, 01 syntax, 02 parameter, 03 other error.
`ifndef SOC_PARAMS_SVH
`define SOC_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SOC_ADDR_CTRL      4'h0
`define SOC_ADDR_STATUS    4'h4
`define SOC_ADDR_INTSTAT   4'h8
`define SOC_ADDR_INTMASK   4'hc
`define SOC_CTRL_ROLE1_LSB 0
`define SOC_CTRL_ROLE2_LSB 2
`define SOC_CTRL_INV1      4
`define SOC_CTRL_INV2      5
`define SOC_CTRL_RESET     6'h05
`define SOC_INTMASK_RESET  3'h0
`define SOC_INT_RESULT     0
`define SOC_INT_CMDERR     1
`define SOC_INT_PORTCHG    2

// ----------------------------------------------------------------
// Characters and codes
// ----------------------------------------------------------------
`define SOC_CH_GATE_ON     8'h2b
`define SOC_CH_GATE_OFF    8'h2d
`define SOC_CH_O           8'h4f
`define SOC_CH_A           8'h41
`define SOC_CH_S           8'h53
`define SOC_CH_I           8'h49
`define SOC_CH_P           8'h50
`define SOC_CH_QUERY       8'h3f
`define SOC_CH_SPACE       8'h20
`define SOC_CH_EQ          8'h3d
`define SOC_CH_SEMI        8'h3b
`define SOC_CH_CR          8'h0d
`define SOC_CH_LF          8'h0a
`define SOC_CH_ZERO        8'h30
`define SOC_CH_ONE         8'h31
`define SOC_CH_TWO         8'h32
`define SOC_CODE_OK        8'h30
`define SOC_CODE_SYNTAX    8'h31
`define SOC_CODE_PARAM     8'h32
`define SOC_CODE_OTHER     8'h33
`define SOC_QUERY_LEN      5'd13
`define SOC_ACK_LEN        5'd6
`define SOC_MAX_LINE       6'd32

`endif

// >>> soc_pkg.sv
/*
  Types of the switch output command handler.
  Assumes soc_params.svh for all figures.
*/
package soc_pkg;

  typedef enum logic [1:0] {
    SOC_ROLE_IN      = 2'h0,
    SOC_ROLE_OUT     = 2'h1,
    SOC_ROLE_PASSIVE = 2'h2
  } soc_role_t;

  typedef enum logic [11:0] {
    SOC_IDLE    = 12'h001,
    SOC_GOT_O   = 12'h002,
    SOC_GOT_A   = 12'h004,
    SOC_ACT     = 12'h008,
    SOC_QRY     = 12'h010,
    SOC_FLD_S   = 12'h020,
    SOC_FLD_N   = 12'h040,
    SOC_FLD_EQ  = 12'h080,
    SOC_FLD_V   = 12'h100,
    SOC_FLD_SEP = 12'h200,
    SOC_ERR     = 12'h400,
    SOC_SKIP    = 12'h800
  } soc_state_t;

endpackage

// >>> soc_reply_if.sv
/*
  Carrier between the command parser and the reply serialiser.
  Assumes one clock; start is a one-cycle pulse taken only while busy is low.
*/
`timescale 1ns/10ps
interface soc_reply_if #(
  parameter int MAX_BYTES = 16
);
  logic                   start;
  logic [8*MAX_BYTES-1:0] msg;
  logic [4:0]             len;
  logic                   busy;

  modport src (output start, output msg, output len, input busy);
  modport snk (input start, input msg, input len, output busy);
endinterface

// >>> soc_port.sv
/*
  One switching port: applies inversion to the logical state, drives the pin
  only in output role, synchronises the pin level back.
  Assumes the pin wire is resolved outside from pinOe.
*/
`timescale 1ns/10ps
module soc_port
  import soc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rstn,
  input  wire soc_role_t role,
  input  wire logic      invert,
  input  wire logic      logicState,
  input  wire logic      pinIn,
  output logic           pinOut,
  output logic           pinOe,
  output logic           pinSync
);
  logic pinMeta;
  wire  isOut = (role == SOC_ROLE_OUT);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinOut  <= 1'b0;
      pinOe   <= 1'b0;
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
    end else begin
      pinOut  <= logicState ^ invert;
      pinOe   <= isOut;
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end
endmodule

// >>> soc_tx.sv
/*
  Reply serialiser: sends a message of up to MAX_BYTES characters, first byte
  in the low lane, over a valid/ready byte stream.
  Assumes the sink may stall txReady for any time.
*/
`timescale 1ns/10ps
module soc_tx #(
  parameter int MAX_BYTES = 16
) (
  input  wire logic   clk,
  input  wire logic   rstn,
  soc_reply_if.snk    rep,
  output logic [7:0]  txData,
  output logic        txValid,
  input  wire logic   txReady
);
  logic [8*MAX_BYTES-1:0] shift;
  logic [4:0]             left;

  if (MAX_BYTES < 13 || MAX_BYTES > 31) begin : g_chk
    $error("soc_tx: MAX_BYTES must lie in 13..31");
  end

  wire take = txValid && txReady;
  wire last = take && (left == 5'd1);

  assign rep.busy = txValid;
  assign txData   = shift[7:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift   <= '0;
      left    <= 5'd0;
      txValid <= 1'b0;
    end else if (rep.start && !txValid && rep.len != 5'd0) begin
      shift   <= rep.msg;
      left    <= rep.len;
      txValid <= 1'b1;
    end else if (take) begin
      shift   <= {8'h00, shift[8*MAX_BYTES-1:8]};
      left    <= left - 5'd1;
      txValid <= !last;
    end
  end
endmodule

// >>> soc_cmd_handler.sv
/*
  Switch output command handler: parses ASCII online commands for the reading
  gate and the two switching ports, drives the ports, answers queries and set
  requests, and holds a small register file with an interrupt.
  Assumes command bytes come from logic on clk; the pins come from outside.
*/
`timescale 1ns/10ps
`include "soc_params.svh"
module soc_cmd_handler
  import soc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  // Command stream
  input  wire logic [7:0]  rxData,
  input  wire logic        rxValid,
  output logic             rxReady,
  output logic [7:0]       txData,
  output logic             txValid,
  input  wire logic        txReady,
  // Gate close sources and read outcome from the decoder
  input  wire logic        closeEvent,
  input  wire logic        successfulReadCriterion,
  output logic             gateOpen,
  output logic             resultValid,
  output logic             failedReadResult,
  // Switching ports
  input  wire logic [1:0]  portIn,
  output logic [1:0]       portOut,
  output logic [1:0]       portOe,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  output logic             irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0] ctrl;
  logic [2:0] intStat;
  logic [2:0] intMask;
  logic [1:0] portState;
  logic [1:0] portSync;

  soc_role_t  role [2];
  logic [1:0] inv;
  assign role[0] = soc_role_t'(ctrl[`SOC_CTRL_ROLE1_LSB +: 2]);
  assign role[1] = soc_role_t'(ctrl[`SOC_CTRL_ROLE2_LSB +: 2]);
  assign inv     = {ctrl[`SOC_CTRL_INV2], ctrl[`SOC_CTRL_INV1]};

  wire selCtrl = (regAddr == `SOC_ADDR_CTRL);
  wire selStat = (regAddr == `SOC_ADDR_STATUS);
  wire selInt  = (regAddr == `SOC_ADDR_INTSTAT);
  wire selMask = (regAddr == `SOC_ADDR_INTMASK);

  wire [31:0] statusWord = {26'h0, failedReadResult, portSync, portState, gateOpen};
  // Unmapped offsets read as zero
  wire [31:0] rdMux = selCtrl ? {26'h0, ctrl} :
                      selStat ? statusWord :
                      selInt  ? {29'h0, intStat} :
                      selMask ? {29'h0, intMask} : 32'h0;

  // ----------------------------------------------------------------
  // Parser
  // ----------------------------------------------------------------
  soc_state_t state;
  soc_state_t next_state;
  logic [1:0] pendVal;
  logic [1:0] pendHas;
  logic [1:0] lastPort;
  logic       fieldPort;
  logic [7:0] errCode;
  logic [5:0] lineLen;

  soc_reply_if #(.MAX_BYTES(16)) rep ();

  wire       rxTake  = rxValid && rxReady;
  wire [7:0] ch      = rxData;
  wire       isTerm  = (ch == `SOC_CH_CR) || (ch == `SOC_CH_LF);
  wire       isPort  = (ch == `SOC_CH_ONE) || (ch == `SOC_CH_TWO);
  wire       isDigit = (ch >= `SOC_CH_ZERO) && (ch <= 8'h39);
  wire       isBit   = (ch == `SOC_CH_ZERO) || (ch == `SOC_CH_ONE);
  wire       portIdx = (ch == `SOC_CH_TWO);
  wire [1:0] portNum = portIdx ? 2'd2 : 2'd1;
  wire       tooLong = (lineLen == `SOC_MAX_LINE);

  // Events decoded from the byte now taken
  wire gateOnCmd  = rxTake && state == SOC_IDLE && ch == `SOC_CH_GATE_ON;
  wire gateOffCmd = rxTake && state == SOC_IDLE && ch == `SOC_CH_GATE_OFF;
  wire actDone    = rxTake && state == SOC_ACT && isTerm;
  wire qryDone    = rxTake && state == SOC_QRY && isTerm;
  wire setEmpty   = rxTake && state == SOC_GOT_A && isTerm;
  wire setDone    = rxTake && isTerm && (state == SOC_FLD_S || state == SOC_FLD_SEP);
  wire errDone    = rxTake && isTerm && state == SOC_ERR;
  wire setErrNew  = rxTake && !isTerm && tooLong && state != SOC_ERR && state != SOC_SKIP
                    && state != SOC_IDLE && state != SOC_GOT_O && state != SOC_GOT_A;

  always_comb begin
    next_state = state;
    case (state)
      SOC_IDLE: begin
        if (ch == `SOC_CH_O) begin
          next_state = SOC_GOT_O;
        end else if (!isTerm && ch != `SOC_CH_GATE_ON && ch != `SOC_CH_GATE_OFF) begin
          next_state = SOC_SKIP;
        end
      end
      SOC_GOT_O: next_state = (ch == `SOC_CH_A) ? SOC_GOT_A : (isTerm ? SOC_IDLE : SOC_SKIP);
      SOC_GOT_A: begin
        if (isPort) begin
          next_state = SOC_ACT;
        end else if (ch == `SOC_CH_QUERY) begin
          next_state = SOC_QRY;
        end else if (ch == `SOC_CH_SPACE) begin
          next_state = SOC_FLD_S;
        end else if (isTerm) begin
          next_state = SOC_IDLE;
        end else begin
          next_state = SOC_SKIP;
        end
      end
      SOC_ACT, SOC_QRY: next_state = isTerm ? SOC_IDLE : SOC_SKIP;
      SOC_FLD_S:   next_state = isTerm ? SOC_IDLE : (ch == `SOC_CH_S ? SOC_FLD_N : SOC_ERR);
      SOC_FLD_N:   next_state = (isPort && portNum > lastPort) ? SOC_FLD_EQ : (isTerm ? SOC_IDLE : SOC_ERR);
      SOC_FLD_EQ:  next_state = (ch == `SOC_CH_EQ) ? SOC_FLD_V : (isTerm ? SOC_IDLE : SOC_ERR);
      SOC_FLD_V:   next_state = isBit ? SOC_FLD_SEP : (isTerm ? SOC_IDLE : SOC_ERR);
      SOC_FLD_SEP: next_state = (ch == `SOC_CH_SEMI) ? SOC_FLD_S : (isTerm ? SOC_IDLE : SOC_ERR);
      SOC_ERR, SOC_SKIP: next_state = isTerm ? SOC_IDLE : state;
      default: next_state = SOC_IDLE;
    endcase
    if (setErrNew) begin
      next_state = SOC_ERR;
    end
  end

  // Error code of the byte that throws the set form into error; a port
  // given out of ascending order counts as a syntax slip
  logic [7:0] next_errCode;
  always_comb begin
    next_errCode = `SOC_CODE_SYNTAX;
    if (setErrNew) begin
      next_errCode = `SOC_CODE_OTHER;
    end else if (state == SOC_FLD_N && isDigit && !isPort) begin
      next_errCode = `SOC_CODE_PARAM;
    end else if (state == SOC_FLD_V && isDigit) begin
      next_errCode = `SOC_CODE_PARAM;
    end
  end

  // A terminator that cuts a field short is a syntax error needing a reply
  wire cutShort = rxTake && isTerm &&
                  (state == SOC_FLD_N || state == SOC_FLD_EQ || state == SOC_FLD_V);
  wire enterErr = rxTake && next_state == SOC_ERR && state != SOC_ERR;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state     <= SOC_IDLE;
      pendVal   <= 2'b00;
      pendHas   <= 2'b00;
      lastPort  <= 2'd0;
      fieldPort <= 1'b0;
      errCode   <= `SOC_CODE_OK;
      lineLen   <= 6'd0;
    end else if (rxTake) begin
      state   <= next_state;
      lineLen <= (next_state == SOC_IDLE) ? 6'd0 : (tooLong ? lineLen : lineLen + 6'd1);
      if (state == SOC_GOT_A) begin
        pendHas  <= 2'b00;
        lastPort <= 2'd0;
      end
      if (state == SOC_GOT_A && isPort) begin
        fieldPort <= portIdx;
      end
      if (state == SOC_FLD_N && next_state == SOC_FLD_EQ) begin
        fieldPort <= portIdx;
        lastPort  <= portNum;
      end
      if (state == SOC_FLD_V && isBit) begin
        pendVal[fieldPort] <= (ch == `SOC_CH_ONE);
        pendHas[fieldPort] <= 1'b1;
      end
      if (enterErr) begin
        errCode <= next_errCode;
      end
    end
  end

  // ----------------------------------------------------------------
  // Port states and gate
  // ----------------------------------------------------------------
  logic [1:0] next_portState;
  always_comb begin
    next_portState = portState;
    if (actDone) begin
      // The selector byte of the activate form was kept in fieldPort, since
      // the byte now taken is the terminator
      next_portState[fieldPort] = 1'b1;
    end
    if (setDone) begin
      for (int i = 0; i < 2; i++) begin
        if (pendHas[i] && role[i] == SOC_ROLE_OUT) begin
          next_portState[i] = pendVal[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      portState        <= 2'b00;
      gateOpen         <= 1'b0;
      resultValid      <= 1'b0;
      failedReadResult <= 1'b0;
    end else begin
      portState   <= next_portState;
      resultValid <= 1'b0;
      if (gateOnCmd) begin
        gateOpen <= 1'b1;
      end else if (gateOpen && gateOffCmd) begin
        gateOpen         <= 1'b0;
        resultValid      <= 1'b1;
        failedReadResult <= 1'b1;
      end else if (gateOpen && closeEvent) begin
        gateOpen         <= 1'b0;
        resultValid      <= 1'b1;
        failedReadResult <= !successfulReadCriterion;
      end
    end
  end

  // ----------------------------------------------------------------
  // Replies
  // ----------------------------------------------------------------
  function automatic logic [7:0] soc_query_char(soc_role_t r, logic s);
    soc_query_char = (r == SOC_ROLE_IN)  ? `SOC_CH_I :
                     (r == SOC_ROLE_OUT) ? (s ? `SOC_CH_ONE : `SOC_CH_ZERO) : `SOC_CH_P;
  endfunction

  wire [7:0] ackCode = errDone || cutShort ? (cutShort ? `SOC_CODE_SYNTAX : errCode) : `SOC_CODE_OK;
  wire [103:0] queryMsg = {`SOC_CH_CR, soc_query_char(role[1], portState[1]), `SOC_CH_EQ,
                           `SOC_CH_TWO, `SOC_CH_S, `SOC_CH_SEMI, soc_query_char(role[0], portState[0]),
                           `SOC_CH_EQ, `SOC_CH_ONE, `SOC_CH_S, `SOC_CH_SPACE, `SOC_CH_A, `SOC_CH_O};
  wire [47:0]  ackMsg = {`SOC_CH_CR, ackCode, `SOC_CH_ZERO, `SOC_CH_EQ, `SOC_CH_A, `SOC_CH_O};
  wire sendAck = setDone || setEmpty || errDone || cutShort;

  assign rep.start = qryDone || sendAck;
  assign rep.msg   = qryDone ? {24'h0, queryMsg} : {80'h0, ackMsg};
  assign rep.len   = qryDone ? `SOC_QUERY_LEN : `SOC_ACK_LEN;
  // Bytes stall while a reply drains, so no reply is ever lost
  assign rxReady   = !rep.busy;

  soc_tx #(.MAX_BYTES(16)) u_tx (
    .clk     (clk),
    .rstn    (rstn),
    .rep     (rep.snk),
    .txData  (txData),
    .txValid (txValid),
    .txReady (txReady)
  );

  for (genvar p = 0; p < 2; p++) begin : g_port
    soc_port u_port (
      .clk        (clk),
      .rstn       (rstn),
      .role       (role[p]),
      .invert     (inv[p]),
      .logicState (portState[p]),
      .pinIn      (portIn[p]),
      .pinOut     (portOut[p]),
      .pinOe      (portOe[p]),
      .pinSync    (portSync[p])
    );
  end

  // ----------------------------------------------------------------
  // Register file and interrupt
  // ----------------------------------------------------------------
  wire [2:0] intEvt = {portState != next_portState, sendAck && ackCode != `SOC_CODE_OK, resultValid};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl     <= `SOC_CTRL_RESET;
      intMask  <= `SOC_INTMASK_RESET;
      intStat  <= 3'h0;
      regRdata <= 32'h0;
    end else begin
      regRdata <= regRd ? rdMux : 32'h0;
      if (regWr && selCtrl) begin
        ctrl <= regWdata[5:0];
      end
      if (regWr && selMask) begin
        intMask <= regWdata[2:0];
      end
      // Set wins over a write-one clear in the same cycle
      intStat <= (intStat & ~((regWr && selInt) ? regWdata[2:0] : 3'h0)) | intEvt;
    end
  end

  assign irq = |(intStat & intMask);
endmodule

// >>> soc_cmd_handler_asserts.sv
/*
  Port checks of the switch output command handler, bound to its top module.
  Assumes one clock and a host that starts every command at a line start.
*/
`timescale 1ns/10ps
`include "soc_params.svh"
module soc_cmd_handler_asserts (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [7:0] rxData,
  input wire logic       rxValid,
  input wire logic       rxReady,
  input wire logic [7:0] txData,
  input wire logic       txValid,
  input wire logic       txReady,
  input wire logic       closeEvent,
  input wire logic       successfulReadCriterion,
  input wire logic       gateOpen,
  input wire logic       resultValid,
  input wire logic       failedReadResult
);
  // ------
  // Line tracking
  // ------
  logic        take;
  logic        isOn;
  logic        isOff;
  logic        isEnd;
  logic        lineStart;
  logic [23:0] hist;
  assign take  = rxValid && rxReady;
  assign isOn  = take && lineStart && rxData == `SOC_CH_GATE_ON;
  assign isOff = take && lineStart && rxData == `SOC_CH_GATE_OFF;
  assign isEnd = take && (rxData == `SOC_CH_CR || rxData == `SOC_CH_LF);
  // Gate characters count only at a line start; inside a line they are data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lineStart <= 1'b1;
      hist      <= 24'h0;
    end else if (take) begin
      lineStart <= isOn || isOff || isEnd;
      hist      <= {hist[15:0], rxData};
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_GATE_ON: assert property (isOn |=> gateOpen)
    else $error("gate did not open");
  AST_GATE_OFF: assert property (isOff && gateOpen |=> !gateOpen)
    else $error("gate did not close");
  AST_RESULT_NOW: assert property (isOff && gateOpen |=> resultValid)
    else $error("no result after close");
  AST_NO_READ: assert property (isOff && gateOpen |=> failedReadResult)
    else $error("manual close gave good read");
  AST_GATE_SILENT: assert property (isOn || isOff |=> !txValid [*2])
    else $error("gate character answered");
  AST_CLOSED_IDLE: assert property (isOff && !gateOpen |=> !resultValid)
    else $error("close while closed made a result");
  AST_RESULT_PULSE: assert property (resultValid |=> !resultValid)
    else $error("result pulse too long");
  AST_EVENT_CLOSE: assert property (closeEvent && gateOpen |=>
    !gateOpen && resultValid && failedReadResult == !$past(successfulReadCriterion))
    else $error("close event mishandled");
  AST_ACT_SILENT: assert property (isEnd && (hist == 24'h4f4131 || hist == 24'h4f4132)
    |=> !txValid [*2])
    else $error("activate answered");
  AST_QUERY_START: assert property (isEnd && hist == 24'h4f413f |=> txValid && txData == `SOC_CH_O)
    else $error("query reply missing");
  AST_REPLY_HOLD: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("reply byte dropped");
  COV_MANUAL_CLOSE: cover property (isOff && gateOpen ##1 resultValid);
  COV_QUERY: cover property (isEnd && hist == 24'h4f413f);
  COV_STALL: cover property (txValid && !txReady);
endmodule

bind soc_cmd_handler soc_cmd_handler_asserts chk_u (
  .clk(clk), .rstn(rstn), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
  .txData(txData), .txValid(txValid), .txReady(txReady), .closeEvent(closeEvent),
  .successfulReadCriterion(successfulReadCriterion), .gateOpen(gateOpen),
  .resultValid(resultValid), .failedReadResult(failedReadResult)
);

// >>> soc_host_model.sv
/*
  Host that sends ASCII command lines and collects reply bytes.
  Assumes tasks are called from the bench just after a rising edge.
*/
`timescale 1ns/10ps
module soc_host_model (
  input  wire logic       clk,
  input  wire logic       slow,
  output logic [7:0]      rxData,
  output logic            rxValid,
  input  wire logic       rxReady,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady
);
  logic [7:0] replyQ[$];
  initial begin
    rxData  = 8'h00;
    rxValid = 1'b0;
  end
  // ------
  // Reply sink
  // ------
  // A slow host takes a byte only every other cycle
  always @(posedge clk) begin
    txReady <= slow ? ~txReady : 1'b1;
    if (txValid && txReady) begin
      replyQ.push_back(txData);
    end
  end
  // ------
  // Command source
  // ------
  // Valid stays up across a line; released data shows the inverse, not a stale byte
  task automatic send_str(input string s);
    int i;
    @(posedge clk);
    rxValid <= 1'b1;
    for (i = 0; i < s.len(); i++) begin
      rxData <= s[i];
      @(posedge clk);
      while (rxReady !== 1'b1) @(posedge clk);
    end
    rxValid <= 1'b0;
    rxData  <= ~s[s.len()-1];
  endtask
endmodule

// >>> soc_cmd_handler_tb.sv
/*
  Self-checking bench of the switch output command handler.
  Assumes the host model on the command stream and pins looped back with pulls.
*/
`timescale 1ns/10ps
`include "soc_params.svh"
module soc_cmd_handler_tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  rxData;
  logic        rxValid;
  logic        rxReady;
  logic [7:0]  txData;
  logic        txValid;
  logic        txReady;
  logic        slowHost = 1'b0;
  logic        closeEvent = 1'b0;
  logic        successfulReadCriterion = 1'b0;
  logic        gateOpen;
  logic        resultValid;
  logic        failedReadResult;
  logic [1:0]  portIn;
  logic [1:0]  portOut;
  logic [1:0]  portOe;
  logic [1:0]  pinExt = 2'h2;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdata;
  logic        irq;
  int          errors = 0;
  int          nChecks = 0;

  always #25 clk = ~clk;
  // Undriven pins settle to their external pulls
  assign portIn = (portOe & portOut) | (~portOe & pinExt);

  soc_cmd_handler dut_u (
    .clk(clk), .rstn(rstn), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .txData(txData), .txValid(txValid), .txReady(txReady), .closeEvent(closeEvent),
    .successfulReadCriterion(successfulReadCriterion), .gateOpen(gateOpen),
    .resultValid(resultValid), .failedReadResult(failedReadResult), .portIn(portIn),
    .portOut(portOut), .portOe(portOe), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq)
  );
  soc_host_model host_u (
    .clk(clk), .slow(slowHost), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .txData(txData), .txValid(txValid), .txReady(txReady)
  );
  // ------
  // Shared tasks
  // ------
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask
  task automatic expect_reply(input string exp);
    int k;
    for (k = 0; k < 4000 && host_u.replyQ.size() < exp.len(); k++) @(posedge clk);
    check("reply length", host_u.replyQ.size(), exp.len());
    for (k = 0; k < exp.len() && host_u.replyQ.size() > 0; k++) check("reply byte", host_u.replyQ.pop_front(), exp[k]);
    host_u.replyQ.delete();
  endtask
  task automatic report_and_stop();
    if (errors == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_gate();
    host_u.send_str("+");
    #1;
    check("gate open", gateOpen, 1'b1);
    host_u.send_str("-");
    #1;
    check("gate closed", gateOpen, 1'b0);
    check("result pulse", resultValid, 1'b1);
    check("failed read", failedReadResult, 1'b1);
    check("no answer", txValid, 1'b0);
    host_u.send_str("-");
    #1;
    check("idle close", resultValid, 1'b0);
    host_u.send_str("+");
    @(posedge clk);
    closeEvent <= 1'b1;
    successfulReadCriterion <= 1'b1;
    @(posedge clk);
    closeEvent <= 1'b0;
    #1;
    check("event close", gateOpen, 1'b0);
    check("good read", failedReadResult, 1'b0);
  endtask
  task automatic t_activate();
    logic [31:0] d;
    reg_rd(4'h2, d);
    check("unmapped read", d, 32'h0);
    reg_rd(`SOC_ADDR_CTRL, d);
    check("ctrl reset", d, 32'h5);
    reg_wr(`SOC_ADDR_CTRL, 32'h25);
    host_u.send_str("OA1\015");
    host_u.send_str("OA2\015");
    repeat (3) @(posedge clk);
    #1;
    check("inverted drive", portOut, 2'h1);
    check("no answer", txValid, 1'b0);
    reg_rd(`SOC_ADDR_STATUS, d);
    check("ports active", d[2:1], 2'h3);
    check("pin levels", d[4:3], 2'h1);
  endtask
  task automatic t_query();
    logic [31:0] ctrlTab[4] = '{32'h9, 32'h1, 32'h15, 32'h5};
    string qryTab[4] = '{"OA S1=1;S2=P\015", "OA S1=1;S2=I\015", "OA S1=1;S2=1\015", "OA S1=1;S2=1\015"};
    int i;
    for (i = 0; i < 4; i++) begin
      reg_wr(`SOC_ADDR_CTRL, ctrlTab[i]);
      slowHost <= i[0];
      host_u.send_str("OA?\015");
      expect_reply(qryTab[i]);
    end
    slowHost <= 1'b0;
  endtask
  task automatic t_set();
    string cmdTab[7] = '{"OA S1=0;S2=0\015", "OA S2=1\015", "OA S2=1;S1=0\015", "OA S1=7\015", "OA S3=1\015",
                         "OA S1=\n", "OA\015"};
    string ackTab[7] = '{"OA=00\015", "OA=00\015", "OA=01\015", "OA=02\015", "OA=02\015", "OA=01\015",
                         "OA=00\015"};
    logic [1:0] outTab[7] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
    logic [31:0] d;
    int i;
    for (i = 0; i < 7; i++) begin
      host_u.send_str(cmdTab[i]);
      #1;
      check("rx stalled", rxReady, 1'b0);
      expect_reply(ackTab[i]);
      check("set pins", portOut, outTab[i]);
    end
    reg_wr(`SOC_ADDR_CTRL, 32'h9);
    host_u.send_str("OA S1=1;S2=0\015");
    expect_reply("OA=00\015");
    reg_rd(`SOC_ADDR_STATUS, d);
    check("passive kept", d[2:1], 2'h3);
    check("passive undriven", portOe, 2'h1);
  endtask
  task automatic t_irq();
    reg_wr(`SOC_ADDR_INTMASK, 32'h0);
    host_u.send_str("OA S1=9\015");
    expect_reply("OA=02\015");
    check("masked", irq, 1'b0);
    reg_wr(`SOC_ADDR_INTMASK, 32'h2);
    #1;
    check("raised", irq, 1'b1);
    reg_wr(`SOC_ADDR_INTSTAT, 32'h2);
    #1;
    check("cleared", irq, 1'b0);
  endtask
  // ------
  // Main sequence and watchdog
  // ------
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_gate();
    t_activate();
    t_query();
    t_set();
    t_irq();
    report_and_stop();
  end
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule
